// ### tb/dram_multipurpose_register_mode_test.sv
`timescale 1ns/1ps
`default_nettype none
module dram_multipurpose_register_mode_test;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] array_data = 16'h1234;
  logic ren;
  logic [1:0] rloc;
  logic [12:0] mode_two;
  logic sref;
  logic [31:0] rd;
  int errors = 0;
  int n_compared = 0;
  mpr_link_if mpr_link_if_i ();
  mpr_device mpr_device_i (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .link(mpr_link_if_i.dev),
    .array_data_in(array_data), .readout_en_out(ren), .readout_loc_out(rloc), .mode_two_out(mode_two),
    .self_refresh_out(sref));
  mpr_controller mpr_controller_i (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(mpr_link_if_i.ctl));
  mpr_properties mpr_properties_i (.clk_in(clk_in), .resetn_in(resetn_in), .ck(mpr_link_if_i.ck),
    .cs_n(mpr_link_if_i.cs_n), .ras_n(mpr_link_if_i.ras_n), .cas_n(mpr_link_if_i.cas_n),
    .we_n(mpr_link_if_i.we_n), .ba(mpr_link_if_i.ba), .addr(mpr_link_if_i.addr), .dq_dev(mpr_link_if_i.dq_dev),
    .dq_dev_oe(mpr_link_if_i.dq_dev_oe), .dq_ctl_oe(mpr_link_if_i.dq_ctl_oe));
  // ************************************************************
  // clock, report and bus tasks
  // ************************************************************
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // waits for hready at a rising edge; a hang ends the run
  task automatic phase();
    int i;
    i = 0;
    do @(posedge clk_in); while (hreadyout !== 1'b1 && ++i < 50);
    if (i >= 50) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    phase();
    htrans <= 2'h0;
    hwdata <= d;
    phase();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // polls busy (bit 0) so a command is never refused
  task automatic cmd(input logic [14:0] a, input logic [2:0] op);
    bus(mpr_pkg::OFS_ADDR, 1'b1, {17'h0, a});
    bus(mpr_pkg::OFS_CMD, 1'b1, {29'h0, op});
    for (int i = 0; i < 400; i++) begin
      bus(mpr_pkg::OFS_STATUS, 1'b0, 32'h0);
      if (rd[0] === 1'b0 && i > 2) break;
      if (i == 399) begin
        errors++;
        end_of_test();
      end
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    chk("ren reset", 32'h0, {31'h0, ren});
    bus(mpr_pkg::OFS_REFRESH, 1'b0, 32'h0);
    chk("refi normal", {16'(mpr_pkg::REFI_NORMAL_CYC), 16'h0}, rd);
    bus(mpr_pkg::OFS_REFRESH, 1'b1, 32'h1);
    bus(mpr_pkg::OFS_REFRESH, 1'b0, 32'h0);
    chk("refi ext", {16'(mpr_pkg::REFI_EXT_CYC), 16'h1}, rd);
    cmd({2'h2, 13'h0080}, mpr_pkg::OP_MRS);
    chk("mode two", 32'h80, {19'h0, mode_two});
    cmd({2'h0, 13'h1fff}, mpr_pkg::OP_MRS);
    cmd({2'h1, 13'h1fff}, mpr_pkg::OP_MRS);
    chk("mode two kept", 32'h80, {19'h0, mode_two});
    chk("ren kept", 32'h0, {31'h0, ren});
    cmd({2'h3, 13'h0004}, mpr_pkg::OP_MRS);
    chk("ren on", 32'h1, {31'h0, ren});
    chk("loc", 32'h0, {30'h0, rloc});
    cmd(15'h0, mpr_pkg::OP_READ);
    bus(mpr_pkg::OFS_RDATA, 1'b0, 32'h0);
    chk("pattern", 32'h1, {31'h0, rd[15:0] === 16'hffff || rd[15:0] === 16'h0000});
    cmd({2'h3, 13'h0001}, mpr_pkg::OP_MRS);
    chk("ren off", 32'h0, {31'h0, ren});
    cmd(15'h0, mpr_pkg::OP_READ);
    bus(mpr_pkg::OFS_RDATA, 1'b0, 32'h0);
    chk("array data", 32'h1234, {16'h0, rd[15:0]});
    cmd(15'h0, mpr_pkg::OP_SELF_REFRESH);
    chk("self refresh", 32'h1, {31'h0, sref});
    bus(8'h20, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    end_of_test();
  end
endmodule
`default_nettype wire

// ### tb/mpr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mpr_properties (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // link
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [mpr_pkg::BANK_W-1:0] ba,
  input wire logic [mpr_pkg::ADDR_W-1:0] addr,
  input wire logic [mpr_pkg::DATA_W-1:0] dq_dev,
  input wire logic dq_dev_oe,
  input wire logic dq_ctl_oe
);
  // ************************************************************
  // command decode and readout mode tracking
  // ************************************************************
  logic mrs_w;
  logic rd_w;
  logic mpr_on_q;
  logic mpr_on_d;
  assign mrs_w = !cs_n && !ras_n && !cas_n && !we_n;
  assign rd_w = !cs_n && ras_n && !cas_n && we_n;
  // follows the last mode set aimed at the control register
  always_comb begin
    mpr_on_d = (mrs_w && ba[1:0] == 2'h3) ? addr[2] : mpr_on_q;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) mpr_on_q <= 1'b0;
    else mpr_on_q <= mpr_on_d;
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_read;
    rd_w && $rose(ck);
  endsequence
  sequence s_burst;
    dq_dev_oe [*8];
  endsequence
  a_bank_two_zero: assert property (mrs_w |-> !ba[2]) else $error("bank bit 2 set in mode set");
  a_high_addr_zero: assert property (mrs_w && ba[1:0] == 2'h3 |-> addr[12:3] == 10'h000)
    else $error("reserved address bits set");
  a_loc_legal: assert property (mrs_w && ba[1:0] == 2'h3 && addr[2] |-> addr[1:0] == 2'h0)
    else $error("reserved location programmed");
  a_ck_divider: assert property ($rose(ck) |-> ##4 $fell(ck)) else $error("link clock period wrong");
  a_read_latency: assert property (s_read |-> ##[8:80] $rose(dq_dev_oe)) else $error("read data late");
  a_burst_len: assert property ($rose(dq_dev_oe) |-> s_burst) else $error("burst cut short");
  a_pattern_out: assert property (dq_dev_oe && mpr_on_q |-> dq_dev == 16'hffff || dq_dev == 16'h0000)
    else $error("readout data not pattern");
  a_no_contention: assert property (!(dq_dev_oe && dq_ctl_oe)) else $error("both ends drive data");
endmodule
`default_nettype wire

// ### verilog/mpr_controller.sv
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mpr_controller (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // link
  mpr_link_if.ctl link
);
  typedef enum logic [1:0] {
    MPC_IDLE = 2'b00,
    MPC_SETUP = 2'b01,
    MPC_HOLD = 2'b10,
    MPC_WAIT = 2'b11
  } mpc_fsm_t;
  typedef struct packed {
    mpc_fsm_t st;
    logic wr_pend;
    logic [7:0] wa;
    logic [2:0] op;
    logic [15:0] addr;
    logic busy;
    logic [3:0] beat;
    logic [1:0] div;
    logic ck;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [12:0] a;
    logic [15:0] rdata;
    logic ext_temp;
    logic [15:0] refi;
    logic [31:0] hrdata;
  } mpc_state_t;
  mpc_state_t s_q, s_d;
  logic [15:0] dq_s1_q, dq_s2_q;
  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + 2'h1;
    if (s_q.div == 2'h3) begin
      s_d.ck = ~s_q.ck;
    end
    // write data phase
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      unique case (s_q.wa)
        mpr_pkg::OFS_CMD: if (!s_q.busy) begin
          s_d.op = hwdata[2:0];
          s_d.busy = 1'b1;
          s_d.st = MPC_SETUP;
        end
        mpr_pkg::OFS_ADDR: s_d.addr = hwdata[15:0];
        mpr_pkg::OFS_REFRESH: s_d.ext_temp = hwdata[0];
        default: ;
      endcase
    end
    // interval follows the flag directly so a read right after a write sees it
    s_d.refi = s_q.ext_temp ? 16'(mpr_pkg::REFI_EXT_CYC) : 16'(mpr_pkg::REFI_NORMAL_CYC);
    if (hsel && htrans[1] && hready) begin
      s_d.wr_pend = hwrite;
      s_d.wa = haddr;
      unique case (haddr)
        mpr_pkg::OFS_STATUS: s_d.hrdata = {31'h0, s_q.busy};
        mpr_pkg::OFS_RDATA: s_d.hrdata = {16'h0, s_q.rdata};
        mpr_pkg::OFS_ADDR: s_d.hrdata = {16'h0, s_q.addr};
        mpr_pkg::OFS_REFRESH: s_d.hrdata = {s_d.refi, 15'h0, s_q.ext_temp};
        default: s_d.hrdata = 32'h0;
      endcase
    end
    // commands change only while the link clock is low
    if (s_q.div == 2'h1 && !s_q.ck) begin
      unique case (s_q.st)
        MPC_IDLE: s_d.cmd = 4'hf;
        MPC_SETUP: begin
          s_d.st = MPC_HOLD;
          // reserved bits forced to zero
          s_d.ba = {1'b0, s_q.addr[14:13]};
          s_d.a = (s_q.addr[14:13] == mpr_pkg::SEL_MULTIPURPOSE) ?
            {10'h000, s_q.addr[2], 2'h0} : s_q.addr[12:0];
          if (s_q.op == mpr_pkg::OP_MRS) s_d.cmd = 4'h0;
          else if (s_q.op == mpr_pkg::OP_READ) s_d.cmd = 4'h5;
          else if (s_q.op == mpr_pkg::OP_SELF_REFRESH) s_d.cmd = 4'h1;
          else s_d.cmd = 4'h7;
        end
        MPC_HOLD: begin
          s_d.cmd = 4'hf;
          s_d.st = (s_q.op == mpr_pkg::OP_READ) ? MPC_WAIT : MPC_IDLE;
          s_d.busy = (s_q.op == mpr_pkg::OP_READ);
          s_d.beat = 4'h0;
        end
        MPC_WAIT: begin
          s_d.beat = s_q.beat + 4'h1;
          if (s_q.beat == 4'(mpr_pkg::READ_LATENCY + 1)) begin
            s_d.rdata = dq_s2_q;
          end
          if (s_q.beat == 4'hf) begin
            s_d.st = MPC_IDLE;
            s_d.busy = 1'b0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else if (ce_in) begin
      s_q <= s_d;
      dq_s1_q <= link.dq;
      dq_s2_q <= dq_s1_q;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign link.ck = s_q.ck;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = s_q.cmd;
  assign link.ba = s_q.ba;
  assign link.addr = s_q.a;
  assign link.dq_ctl = 16'h0000;
  assign link.dq_ctl_oe = 1'b0;
endmodule
`default_nettype wire

// ### verilog/mpr_device.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - mode set with bank 3 loads control
// - bank bits 1:0 select target mode register
// - address bit 2 routes reads from readout
// - location 00 is predefined pattern, others reserved
// - location ignored while readout disabled
// - controller zeroes bank bit 2, and address 3-12 on bank 3 mode sets
// - pattern supplied for read synchronization
// - extended temperature halves refresh interval
// - mode two self-refresh bits set before entry; the device enters self-refresh on the command without checking them
module mpr_device #(
  parameter int READ_LAT = mpr_pkg::READ_LATENCY
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // link
  mpr_link_if.dev link,
  // array read data from user side
  input wire logic [mpr_pkg::DATA_W-1:0] array_data_in,
  // status
  output logic readout_en_out,
  output logic [1:0] readout_loc_out,
  output logic [mpr_pkg::ADDR_W-1:0] mode_two_out,
  output logic self_refresh_out
);
  typedef struct packed {
    logic [2:0] ck_sync;
    logic [2:0][5:0] cmd_sync;
    logic ck_prev;
    logic [mpr_pkg::ADDR_W-1:0] mpc;
    logic [mpr_pkg::ADDR_W-1:0] mr0;
    logic [mpr_pkg::ADDR_W-1:0] mr1;
    logic [mpr_pkg::ADDR_W-1:0] mr2;
    logic [7:0] lat;
    logic [3:0] beat;
    logic drive;
    logic [mpr_pkg::DATA_W-1:0] dq;
    logic sref;
  } mpd_state_t;
  mpd_state_t s_q, s_d;
  logic [mpr_pkg::ADDR_W+mpr_pkg::BANK_W-1:0] cmd_addr;
  logic ck_rise;
  logic [3:0] cmd;
  // address and bank are held stable by the controller across the edge
  assign cmd_addr = {link.ba, link.addr};
  assign ck_rise = s_q.ck_sync[2] & s_q.ck_sync[1] & ~s_q.ck_prev;
  assign cmd = s_q.cmd_sync[2][3:0];
  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ck_sync = {s_q.ck_sync[1:0], link.ck};
    s_d.cmd_sync = {s_q.cmd_sync[1:0], {2'h0, link.cs_n, link.ras_n, link.cas_n, link.we_n}};
    if (s_q.ck_sync[2] == s_q.ck_sync[1]) begin
      s_d.ck_prev = s_q.ck_sync[2];
    end
    if (ck_rise) begin
      // a mode set with bank bit 2 high addresses no register here
      if (cmd == 4'h0 && !cmd_addr[mpr_pkg::ADDR_W+2]) begin
        unique case (cmd_addr[mpr_pkg::ADDR_W+1:mpr_pkg::ADDR_W])
          mpr_pkg::SEL_MODE_ZERO: s_d.mr0 = cmd_addr[mpr_pkg::ADDR_W-1:0];
          mpr_pkg::SEL_MODE_ONE: s_d.mr1 = cmd_addr[mpr_pkg::ADDR_W-1:0];
          mpr_pkg::SEL_MODE_TWO: s_d.mr2 = cmd_addr[mpr_pkg::ADDR_W-1:0];
          mpr_pkg::SEL_MULTIPURPOSE: s_d.mpc = cmd_addr[mpr_pkg::ADDR_W-1:0];
        endcase
      end else if (cmd == 4'h5) begin
        // read: start latency count, same for array and readout
        s_d.lat = 8'(READ_LAT);
      end else if (cmd == 4'h1) begin
        s_d.sref = 1'b1;
      end else if (cmd == 4'h7) begin
        s_d.sref = 1'b0;
      end
      if (s_q.lat != 8'h00) begin
        s_d.lat = s_q.lat - 8'h01;
        if (s_q.lat == 8'h01) begin
          s_d.beat = 4'(mpr_pkg::BURST_LEN);
        end
      end
      if (s_q.beat != 4'h0) begin
        s_d.beat = s_q.beat - 4'h1;
        s_d.drive = 1'b1;
        // location is never decoded; readout enable alone picks pattern or array data
        if (s_q.mpc[mpr_pkg::MPC_ENABLE_BIT]) begin
          // reserved locations fall back to the pattern
          s_d.dq = s_q.beat[0] ? mpr_pkg::PATTERN_EVEN : mpr_pkg::PATTERN_ODD;
        end else begin
          s_d.dq = array_data_in;
        end
      end else begin
        s_d.drive = 1'b0;
      end
    end
  end
  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end
  assign link.dq_dev = s_q.dq;
  assign link.dq_dev_oe = s_q.drive;
  assign readout_en_out = s_q.mpc[mpr_pkg::MPC_ENABLE_BIT];
  assign readout_loc_out = s_q.mpc[mpr_pkg::MPC_LOC_HI:mpr_pkg::MPC_LOC_LO];
  assign mode_two_out = s_q.mr2;
  assign self_refresh_out = s_q.sref;
endmodule
`default_nettype wire

// ### verilog/mpr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mpr_link_if;
  logic ck;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [mpr_pkg::BANK_W-1:0] ba;
  logic [mpr_pkg::ADDR_W-1:0] addr;
  logic [mpr_pkg::DATA_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [mpr_pkg::DATA_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic [mpr_pkg::DATA_W-1:0] dq;
  assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);
  modport ctl (output ck, cs_n, ras_n, cas_n, we_n, ba, addr, dq_ctl, dq_ctl_oe, input dq);
  modport dev (input ck, cs_n, ras_n, cas_n, we_n, ba, addr, dq, output dq_dev, dq_dev_oe);
endinterface
`default_nettype wire

// ### verilog/mpr_pkg.sv
package mpr_pkg;
  // ************************************************************
  // command and address field layout
  // ************************************************************
  localparam int ADDR_W = 13;
  localparam int BANK_W = 3;
  localparam int DATA_W = 16;
  localparam int BURST_LEN = 8;
  localparam logic [1:0] SEL_MODE_ZERO = 2'h0;
  localparam logic [1:0] SEL_MODE_ONE = 2'h1;
  localparam logic [1:0] SEL_MODE_TWO = 2'h2;
  localparam logic [1:0] SEL_MULTIPURPOSE = 2'h3;
  localparam int MPC_ENABLE_BIT = 2;
  localparam int MPC_LOC_HI = 1;
  localparam int MPC_LOC_LO = 0;
  localparam logic [1:0] LOC_PREDEFINED = 2'h0;
  localparam logic [ADDR_W-1:0] MPC_RESET = 13'h0000;
  // pattern bursts alternate ones and zeros for read capture training
  localparam logic [DATA_W-1:0] PATTERN_ODD = 16'hffff;
  localparam logic [DATA_W-1:0] PATTERN_EVEN = 16'h0000;
  // mode register two self-refresh bits
  localparam int ASR_BIT = 6;
  localparam int SRT_BIT = 7;
  localparam int READ_LATENCY = 4;
  // ************************************************************
  // host register map (ahb-lite, word aligned)
  // ************************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_REFRESH = 8'h10;
  localparam logic [2:0] OP_MRS = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_REFRESH = 3'h3;
  localparam logic [2:0] OP_SELF_REFRESH = 3'h4;
  // refresh interval figures in ns, cycle counts at 200 MHz
  localparam int CLK_NS = 5;
  localparam int REFI_NORMAL_NS = 7800;
  localparam int REFI_EXT_NS = 3900;
  localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS / CLK_NS;
  localparam int REFI_EXT_CYC = REFI_EXT_NS / CLK_NS;
  localparam int LINK_DIV = 4;
endpackage
